// ---- etc_pkg.sv ----
// Constants shared by the event timer compare block
`default_nettype none
package etc_pkg;
   // Register addresses on the serial port
   localparam logic [5:0]  ETC_ADR_MASK   = 6'h05;
   localparam logic [5:0]  ETC_ADR_CTRL_A = 6'h06;
   localparam logic [5:0]  ETC_ADR_CTRL_B = 6'h07;
   localparam logic [5:0]  ETC_ADR_CMP_HI = 6'h1b;
   localparam logic [5:0]  ETC_ADR_STREAM = 6'h23;
   localparam logic [5:0]  ETC_ADR_STATUS = 6'h24;
   localparam logic [5:0]  ETC_ADR_TIME_HI = 6'h26;
   localparam logic [5:0]  ETC_ADR_TIME_LO = 6'h27;
   localparam logic [5:0]  ETC_ADR_STEP   = 6'h02;
   // Status flag positions
   localparam int          ETC_FLG_CMP1   = 8;
   localparam int          ETC_FLG_CMP2   = 2;
   localparam int          ETC_FLG_CMP3   = 4;
   localparam int          ETC_FLG_CMP4   = 3;
   localparam int          ETC_FLG_WAKE   = 9;
   // Mask register fields
   localparam int          ETC_MSK_WAKE   = 4;
   localparam int          ETC_MSK_DEEP   = 8;
   // Control fields
   localparam int          ETC_CA_TRIG_EN = 7;
   localparam int          ETC_CA_OP_LSB  = 0;
   localparam int          ETC_CB_SLEEP   = 0;
   localparam int          ETC_CB_STREAM  = 1;
   localparam int          ETC_CB_RX_STRM = 2;
   localparam int          ETC_CB_TX_STRM = 3;
   localparam int          ETC_CMP_OFF    = 15;
   // Reset values
   localparam logic [15:0] ETC_RST_MASK   = 16'h0000;
   localparam logic [15:0] ETC_RST_CTRL   = 16'h0000;
   localparam logic [15:0] ETC_RST_FLAGS  = 16'h0000;
   localparam logic [23:0] ETC_RST_CMP    = 24'h000000;
   localparam logic [23:0] ETC_RST_COUNT  = 24'h000000;
   localparam logic        ETC_RST_OFF    = 1'b0;
   // Serial framing
   localparam int          ETC_HDR_BITS   = 8;
   localparam int          ETC_HDR_RD     = 7;
   localparam int          ETC_WORD_BITS  = 16;
   // Timer clock: count periods of the system clock per time step
   localparam int          ETC_TICK_DIV   = 1;

   typedef enum logic [2:0] {
      ETC_ST_IDLE = 3'b001,
      ETC_ST_HDR  = 3'b010,
      ETC_ST_DATA = 3'b100
   } etc_spi_st_t;
endpackage
`default_nettype wire

// ---- etc_event_timer_compare.sv ----
// Event timer comparators, status flags, sleep exit and timer trigger
//
// Notes on behaviour
// RULE_01: Enabled comparator match sets its flag: bits 8, 2, 4, 3.
// RULE_02: Flags hold until status read or comparator disable write.
// RULE_03: Mask bits 0 to 3 gate comparator flags onto interrupt pin.
// RULE_04: Enabled, set flag keeps interrupt active until status read clears it.
// RULE_05: Writing upper compare address inhibits match until lower word written.
// RULE_06: Host updates compare with two-word write from upper address.
// RULE_07: Reset leaves comparators enabled and all interrupt masks clear.
// RULE_08: Host disables comparators and reads status once after reset.
// RULE_09: Flag set on every enabled match; pin follows only when masked in.
// RULE_10: Enabled comparator matches again after each counter wrap.
// RULE_11: Writing sleep request bit 0 of control B enters sleep.
// RULE_12: Sleeping comparator two match wakes, sets bit 9, mask bit 4.
// RULE_13: Sleep wake match ignores comparator two disable bit.
// RULE_14: Attention pin or reset always ends sleep.
// RULE_15: Deep sleep bit 8 stops timer; only attention or reset wake.
// RULE_16: Trigger enable bit 7 starts sequence on trigger match.
// RULE_17: Packet mode uses comparator two; stream uses low 16 bits.
// RULE_18: Stream trigger works only while comparator two is enabled.
// RULE_19: Trigger enable is a level; no clearing between operations.
// RULE_20: Host arms with op enable pin low, then drives it high.
// RULE_21: Host loads transmit length and data before trigger enable.
// RULE_22: Trigger start sets comparator two flag and its interrupt.
// RULE_23: Count is 24 bits, zero after reset, wraps after maximum.
// RULE_24: Disable write clears that comparator flag and its interrupt.
// RULE_25: Status read clears all flags and releases interrupt pin.
// RULE_26: One set event per matching count value, not repeated.
`default_nettype none
module etc_event_timer_compare
   import etc_pkg::*;
#(
   parameter int TICK_DIV = ETC_TICK_DIV
) (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   input  wire logic        spi_clk,
   input  wire logic        spi_sel_n,
   input  wire logic        spi_mosi,
   input  wire logic        attn_n,
   input  wire logic        radio_op_enable_pin,
   output logic             spi_miso,
   output logic             spi_miso_oe,
   output logic             irq_n,
   output logic             sleeping,
   output logic             trig_start,
   output logic             trig_stream,
   output logic [1:0]       trig_op,
   output logic [23:0]      current_count
);

   function automatic logic [5:0] hi_adr(input int i);
      hi_adr = ETC_ADR_CMP_HI + 6'(2 * i);
   endfunction

   function automatic int flag_pos(input int i);
      case (i)
         0: flag_pos = ETC_FLG_CMP1;
         1: flag_pos = ETC_FLG_CMP2;
         2: flag_pos = ETC_FLG_CMP3;
         default: flag_pos = ETC_FLG_CMP4;
      endcase
   endfunction

   // Pin synchronisers; first stage feeds only the second
   logic [2:0]  sck_s;
   logic [1:0]  sel_s;
   logic [1:0]  mosi_s;
   logic [1:0]  attn_s;
   logic [1:0]  rxtx_s;

   etc_spi_st_t state_r;
   logic [3:0]  bit_cnt_r;
   logic [15:0] rx_sr_r;
   logic [15:0] tx_sr_r;
   logic [5:0]  addr_r;
   logic        rd_mode_r;

   logic [15:0] mask_r;
   logic [15:0] ctrl_a_r;
   logic [15:0] ctrl_b_r;
   logic [15:0] stream_val_r;
   logic [15:0] flag_r;
   logic [15:0] flag_nxt;
   logic [23:0] cmp_val_r [4];
   logic [3:0]  cmp_off_r;
   logic [3:0]  inhibit_r;
   logic        deep_r;
   logic [23:0] cur_r;
   logic        fresh_r;
   logic [15:0] tick_r;
   logic        trig_start_r;
   logic        trig_stream_r;
   logic [1:0]  trig_op_r;

   // Serial decode
   wire         sel_act    = ~sel_s[1];
   wire         sck_rise   = sck_s[1] & ~sck_s[2];
   wire [15:0]  rx_word    = {rx_sr_r[14:0], mosi_s[1]};
   wire         hdr_done   = (state_r == ETC_ST_HDR) & sck_rise &
                             (bit_cnt_r == 4'(ETC_HDR_BITS - 1));
   wire         word_done  = (state_r == ETC_ST_DATA) & sck_rise &
                             (bit_cnt_r == 4'(ETC_WORD_BITS - 1));
   wire         word_start = hdr_done | word_done;
   wire [5:0]   next_addr  = hdr_done ? rx_word[5:0] : addr_r + 6'h01;
   wire         next_rd    = hdr_done ? rx_word[ETC_HDR_RD] : rd_mode_r;
   wire         rd_load    = word_start & next_rd;
   wire         status_rd  = rd_load & (next_addr == ETC_ADR_STATUS);
   wire         wr_strobe  = word_done & ~rd_mode_r;
   wire         wr_new     = word_start & ~next_rd;
   wire         wr_ctrl_b  = wr_strobe & (addr_r == ETC_ADR_CTRL_B);

   // Timer and comparators
   wire         timer_run  = ~(sleeping & deep_r); // RULE_15
   wire         step       = timer_run & (tick_r == 16'(TICK_DIV - 1));
   wire         attn_act   = ~attn_s[1];
   wire         stream_md  = ctrl_b_r[ETC_CB_STREAM];
   logic [3:0]  cmp_eq;
   logic [3:0]  cmp_hit;
   logic [3:0]  off_wr;
   logic [15:0] rd_mux;
   logic [15:0] irq_en;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         // Only the cycle after a step may match, so a held count
         // cannot set a flag twice
         cmp_eq[i]  = fresh_r & ~inhibit_r[i] &
                      (cur_r == cmp_val_r[i]); // RULE_05 RULE_26
         cmp_hit[i] = cmp_eq[i] & ~cmp_off_r[i]; // RULE_01 RULE_10
         off_wr[i]  = wr_strobe & (addr_r == hi_adr(i)) &
                      rx_word[ETC_CMP_OFF];
      end
   end

   wire wake_hit = sleeping & ~deep_r & cmp_eq[1]; // RULE_12 RULE_13
   wire strm_hit = fresh_r & ~cmp_off_r[1] &
                   (cur_r[15:0] == stream_val_r); // RULE_17 RULE_18
   wire trig_src = stream_md ? strm_hit : cmp_hit[1]; // RULE_17
   wire trig_hit = ctrl_a_r[ETC_CA_TRIG_EN] & rxtx_s[1] &
                   ~sleeping & trig_src; // RULE_16 RULE_19

   always_comb begin
      logic [15:0] set_v;
      logic [15:0] clr_v;
      set_v = 16'h0000;
      clr_v = status_rd ? 16'hffff : 16'h0000; // RULE_25
      for (int i = 0; i < 4; i++) begin
         set_v[flag_pos(i)] = cmp_hit[i]; // RULE_09
         if (off_wr[i]) begin
            clr_v[flag_pos(i)] = 1'b1; // RULE_24
         end
      end
      set_v[ETC_FLG_CMP2] = cmp_hit[1] | trig_hit; // RULE_22
      set_v[ETC_FLG_WAKE] = wake_hit;
      // A new event in the clearing cycle survives
      flag_nxt = (flag_r & ~clr_v) | set_v; // RULE_02
   end

   always_comb begin
      irq_en = 16'h0000;
      for (int i = 0; i < 4; i++) begin
         irq_en[flag_pos(i)] = mask_r[i]; // RULE_03
      end
      irq_en[ETC_FLG_WAKE] = mask_r[ETC_MSK_WAKE]; // RULE_12
   end

   always_comb begin
      rd_mux = 16'h0000;
      case (next_addr)
         ETC_ADR_MASK:    rd_mux = mask_r;
         ETC_ADR_CTRL_A:  rd_mux = ctrl_a_r;
         ETC_ADR_CTRL_B:  rd_mux = ctrl_b_r;
         ETC_ADR_STREAM:  rd_mux = stream_val_r;
         ETC_ADR_STATUS:  rd_mux = flag_r;
         ETC_ADR_TIME_HI: rd_mux = {8'h00, cur_r[23:16]};
         ETC_ADR_TIME_LO: rd_mux = cur_r[15:0];
         default: begin
            for (int i = 0; i < 4; i++) begin
               if (next_addr == hi_adr(i)) begin
                  rd_mux = {cmp_off_r[i], 7'h00, cmp_val_r[i][23:16]};
               end
               if (next_addr == hi_adr(i) + ETC_ADR_STEP - 6'h01) begin
                  rd_mux = cmp_val_r[i][15:0];
               end
            end
         end
      endcase
   end

   assign spi_miso      = tx_sr_r[15];
   assign spi_miso_oe   = sel_act & rd_mode_r & (state_r == ETC_ST_DATA);
   assign irq_n         = ~|(flag_r & irq_en); // RULE_04
   assign sleeping      = ctrl_b_r[ETC_CB_SLEEP];
   assign trig_start    = trig_start_r;
   assign trig_stream   = trig_stream_r;
   assign trig_op       = trig_op_r;
   assign current_count = cur_r;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sck_s  <= 3'h0;
         sel_s  <= 2'h3;
         mosi_s <= 2'h0;
         attn_s <= 2'h3;
         rxtx_s <= 2'h0;
      end else if (clk_en) begin
         sck_s  <= {sck_s[1:0], spi_clk};
         sel_s  <= {sel_s[0], spi_sel_n};
         mosi_s <= {mosi_s[0], spi_mosi};
         attn_s <= {attn_s[0], attn_n};
         rxtx_s <= {rxtx_s[0], radio_op_enable_pin};
      end
   end

   // Serial engine: sample and shift on the rising link clock edge,
   // well after the host has sampled the previous output bit
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_r   <= ETC_ST_IDLE;
         bit_cnt_r <= 4'h0;
         rx_sr_r   <= 16'h0000;
         tx_sr_r   <= 16'h0000;
         addr_r    <= 6'h00;
         rd_mode_r <= 1'b0;
      end else if (clk_en) begin
         if (!sel_act) begin
            state_r <= ETC_ST_IDLE;
         end else begin
            unique case (state_r)
               ETC_ST_IDLE: begin
                  state_r   <= ETC_ST_HDR;
                  bit_cnt_r <= 4'h0;
               end
               ETC_ST_HDR, ETC_ST_DATA: begin
                  if (sck_rise) begin
                     rx_sr_r   <= rx_word;
                     bit_cnt_r <= hdr_done ? 4'h0 : bit_cnt_r + 4'h1;
                     tx_sr_r   <= {tx_sr_r[14:0], 1'b0};
                  end
                  if (hdr_done) begin
                     state_r <= ETC_ST_DATA;
                  end
               end
            endcase
         end
         if (word_start) begin
            addr_r    <= next_addr;
            rd_mode_r <= next_rd;
         end
         if (rd_load) begin
            tx_sr_r <= rd_mux;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mask_r       <= ETC_RST_MASK; // RULE_07
         ctrl_a_r     <= ETC_RST_CTRL;
         stream_val_r <= ETC_RST_CMP[15:0];
      end else if (clk_en && wr_strobe) begin
         case (addr_r)
            ETC_ADR_MASK:   mask_r       <= rx_word;
            ETC_ADR_CTRL_A: ctrl_a_r     <= rx_word;
            ETC_ADR_STREAM: stream_val_r <= rx_word;
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (reset) begin
            cmp_val_r[i] <= ETC_RST_CMP;
            cmp_off_r[i] <= ETC_RST_OFF; // RULE_07
            inhibit_r[i] <= 1'b0;
         end else if (clk_en) begin
            if (wr_strobe && addr_r == hi_adr(i)) begin
               cmp_val_r[i][23:16] <= rx_word[7:0];
               cmp_off_r[i]        <= rx_word[ETC_CMP_OFF];
            end
            if (wr_strobe &&
                addr_r == hi_adr(i) + ETC_ADR_STEP - 6'h01) begin
               cmp_val_r[i][15:0] <= rx_word;
               inhibit_r[i]       <= 1'b0; // RULE_05
            end
            if (wr_new && next_addr == hi_adr(i)) begin
               inhibit_r[i] <= 1'b1; // RULE_05
            end
         end
      end
   end

   // Sleep control; a wake clears the request bit so software sees idle
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ctrl_b_r <= ETC_RST_CTRL; // RULE_14
         deep_r   <= 1'b0;
      end else if (clk_en) begin
         if (wr_ctrl_b) begin
            ctrl_b_r <= rx_word; // RULE_11
            if (rx_word[ETC_CB_SLEEP] && !sleeping) begin
               deep_r <= mask_r[ETC_MSK_DEEP]; // RULE_15
            end
         end
         if (sleeping && (wake_hit || attn_act)) begin
            ctrl_b_r[ETC_CB_SLEEP] <= 1'b0; // RULE_12 RULE_14
            deep_r                 <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cur_r   <= ETC_RST_COUNT; // RULE_23
         tick_r  <= 16'h0000;
         fresh_r <= 1'b0;
         flag_r  <= ETC_RST_FLAGS;
      end else if (clk_en) begin
         fresh_r <= step;
         flag_r  <= flag_nxt;
         if (timer_run) begin
            tick_r <= step ? 16'h0000 : tick_r + 16'h0001;
         end
         if (step) begin
            cur_r <= cur_r + 24'h000001; // RULE_23
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         trig_start_r  <= 1'b0;
         trig_stream_r <= 1'b0;
         trig_op_r     <= 2'h0;
      end else if (clk_en) begin
         trig_start_r <= trig_hit; // RULE_16
         if (trig_hit) begin
            trig_stream_r <= stream_md;
            trig_op_r     <= stream_md ?
               {ctrl_b_r[ETC_CB_TX_STRM], ctrl_b_r[ETC_CB_RX_STRM]} :
               ctrl_a_r[ETC_CA_OP_LSB +: 2];
         end
      end
   end

endmodule
`default_nettype wire

// ---- etc_event_timer_compare_chk.sv ----
// Port-level assertions for the event timer compare block
`default_nettype none
module etc_event_timer_compare_chk
   import etc_pkg::*;
#(
   parameter int TICK_DIV = ETC_TICK_DIV
) (
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        clk_en,
   input wire logic        spi_clk,
   input wire logic        spi_sel_n,
   input wire logic        spi_mosi,
   input wire logic        attn_n,
   input wire logic        radio_op_enable_pin,
   input wire logic        spi_miso,
   input wire logic        spi_miso_oe,
   input wire logic        irq_n,
   input wire logic        sleeping,
   input wire logic        trig_start,
   input wire logic        trig_stream,
   input wire logic [1:0]  trig_op,
   input wire logic [23:0] current_count
);
   // Cycles since select went high; register writes land only near frames
   logic [7:0] idle_r;
   always_ff @(posedge sys_clk) begin
      if (reset || !spi_sel_n) idle_r <= 8'h00;
      else if (idle_r != 8'hff) idle_r <= idle_r + 8'h01;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   cnt_step_a: assert property
      (TICK_DIV == 1 && clk_en && $past(clk_en)
      && !sleeping && !$past(sleeping) && !$past(reset)
      |-> current_count == $past(current_count) + 24'h000001)
      else $error("count did not step by one");
   cnt_reset_a: assert property
      (disable iff (1'b0) reset ##1 reset
      |-> current_count == 24'h000000 && irq_n && !sleeping && !trig_start)
      else $error("reset state wrong");
   irq_hold_a: assert property
      (!irq_n && idle_r > 8'h06 |=> !irq_n)
      else $error("interrupt released without a frame");
   attn_wake_a: assert property (!attn_n [*6] |-> !sleeping)
      else $error("attention did not end sleep");
   sleep_entry_a: assert property
      ($rose(sleeping) |-> idle_r < 8'h06)
      else $error("sleep entered without a write");
   trig_pulse_a: assert property (trig_start |=> !trig_start)
      else $error("trigger pulse too long");
   trig_cond_a: assert property (trig_start |-> !sleeping
      && ($past(radio_op_enable_pin, 2) || $past(radio_op_enable_pin, 3)))
      else $error("trigger without enable pin");
   trig_mark_a: assert property
      ($changed(trig_stream) || $changed(trig_op) |-> trig_start)
      else $error("trigger mode changed without a trigger");
   // Output enable only while the synced select is still active
   miso_drive_a: assert property (spi_miso_oe |-> !$past(spi_sel_n, 2))
      else $error("data out driven outside a frame");
   trig_c: cover property (trig_start);
   wake_c: cover property ($fell(sleeping) && attn_n);
   irq_c: cover property ($fell(irq_n));
endmodule
bind etc_event_timer_compare etc_event_timer_compare_chk #(
   .TICK_DIV(TICK_DIV)
) chk_i (
   .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .spi_clk(spi_clk),
   .spi_sel_n(spi_sel_n), .spi_mosi(spi_mosi), .attn_n(attn_n),
   .radio_op_enable_pin(radio_op_enable_pin), .spi_miso(spi_miso),
   .spi_miso_oe(spi_miso_oe), .irq_n(irq_n), .sleeping(sleeping),
   .trig_start(trig_start), .trig_stream(trig_stream), .trig_op(trig_op),
   .current_count(current_count)
);
`default_nettype wire

// ---- etc_host_model.sv ----
// Host controller model driving the serial register port
`default_nettype none
module etc_host_model (
   input  wire logic sys_clk,
   input  wire logic spi_miso,
   output var logic  spi_clk,
   output var logic  spi_sel_n,
   output var logic  spi_mosi
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      spi_clk = 1'b0;
      spi_sel_n = 1'b1;
      spi_mosi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // One frame: header then nw words, 800 ns bit period, clock idle low
   task automatic xfer(input logic rd, input logic [5:0] a,
                       input logic [31:0] wd, input int nw,
                       output logic [31:0] rv);
      logic [7:0]  h;
      logic [31:0] sh;
      h = {rd, 1'b0, a};
      sh = (nw == 2) ? wd : {wd[15:0], 16'h0000};
      rv = 32'h00000000;
      spi_sel_n <= 1'b0;
      tick(4);
      for (int i = 0; i < 8 + 16 * nw; i++) begin
         spi_mosi <= (i < 8) ? h[7 - i] : sh[39 - i];
         tick(4);
         spi_clk <= 1'b1;
         if (i >= 8) rv = {rv[30:0], spi_miso};
         tick(4);
         spi_clk <= 1'b0;
      end
      tick(4);
      spi_sel_n <= 1'b1;
      // Released data line must not keep looking valid
      spi_mosi <= ~spi_mosi;
      tick(4);
   endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the event timer compare block
`default_nettype none
module tb_top;
   import etc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, reset, clk_en, attn_n, pin, miso, oe, irq_n, slp;
   logic spi_clk, sel_n, mosi, tstart, tstrm;
   logic [1:0]  top;
   logic [23:0] cnt, t, c0;
   logic [31:0] rd_val, seed_v, m, op, dummy;
   logic [31:0] exp_q[$];
   int fail_count, check_count, trig_n;
   int flg[4] = '{ETC_FLG_CMP1, ETC_FLG_CMP2, ETC_FLG_CMP3, ETC_FLG_CMP4};
   event rd_ev;
   etc_event_timer_compare #(.TICK_DIV(1)) etc_event_timer_compare_i (
      .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .spi_clk(spi_clk),
      .spi_sel_n(sel_n), .spi_mosi(mosi), .attn_n(attn_n),
      .radio_op_enable_pin(pin), .spi_miso(miso), .spi_miso_oe(oe),
      .irq_n(irq_n), .sleeping(slp), .trig_start(tstart),
      .trig_stream(tstrm), .trig_op(top), .current_count(cnt));
   etc_host_model etc_host_model_i (.sys_clk(sys_clk), .spi_miso(miso),
      .spi_clk(spi_clk), .spi_sel_n(sel_n), .spi_mosi(mosi));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (fail_count == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(rd_ev) check(rd_val, exp_q.pop_front());
   always @(posedge sys_clk) if (tstart === 1'b1) trig_n++;
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      etc_host_model_i.xfer(1'b1, a, 32'h0, 1, rd_val);
      ->rd_ev;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input int n);
      etc_host_model_i.xfer(1'b0, a, d, n, dummy);
   endtask
   task automatic bail();
      fail_count++;
      give_verdict();
   endtask
   task automatic wait_cnt(input logic [23:0] tg);
      int k;
      for (k = 0; k < 20000 && cnt !== tg; k++) @(negedge sys_clk);
      if (k == 20000) bail();
   endtask
   task automatic wait_trig();
      int k, n0;
      n0 = trig_n;
      for (k = 0; k < 20000 && trig_n == n0; k++) @(negedge sys_clk);
      if (k == 20000) bail();
   endtask
   initial begin
      reset = 1'b1;
      clk_en = 1'b1;
      attn_n = 1'b1;
      pin = 1'b0;
      fail_count = 0;
      check_count = 0;
      trig_n = 0;
      seed_v = $urandom(32'h2c655a21);
      repeat (12) @(negedge sys_clk);
      reset = 1'b0;
      repeat (4) @(negedge sys_clk);
      rd(ETC_ADR_MASK, 32'h0);
      rd(ETC_ADR_STATUS, 32'h0);
      for (int k = 0; k < 4; k++) begin
         wr(ETC_ADR_CMP_HI + 6'(2 * k), 32'h80000000, 2);
      end
      // Each comparator with a random mask; the third also sees inhibit
      for (int k = 0; k < 5; k++) begin
         m = $urandom % 2;
         wr(ETC_ADR_MASK, m << (k % 4), 1);
         t = cnt + 24'd3000;
         wr(ETC_ADR_CMP_HI + 6'(2 * (k % 4)), {8'h00, t}, 2);
         if (k == 2) wr(ETC_ADR_CMP_HI + 6'h04, {24'h0, t[23:16]}, 1);
         wait_cnt(t + 24'd8);
         if (k == 2) rd(ETC_ADR_STATUS, 32'h0);
         else check(irq_n, {31'h0, ~m[0]});
         // The fifth pass reuses comparator one, so disable that one
         if (k == 4) wr(ETC_ADR_CMP_HI, 32'h80000000, 2);
         if (k == 4) check(irq_n, 32'h1);
         if (k < 2 || k == 3) rd(ETC_ADR_STATUS, 32'h1 << flg[k]);
         if (k != 2) rd(ETC_ADR_STATUS, 32'h0);
         check(irq_n, 32'h1);
      end
      // Wake on comparator two while it is disabled
      wr(ETC_ADR_MASK, 32'h1 << ETC_MSK_WAKE, 1);
      t = cnt + 24'd3000;
      wr(ETC_ADR_CMP_HI + 6'h02, {8'h80, t}, 2);
      wr(ETC_ADR_CTRL_B, 32'h1, 1);
      check(slp, 32'h1);
      wait_cnt(t + 24'd8);
      check(slp, 32'h0);
      check(irq_n, 32'h0);
      rd(ETC_ADR_STATUS, 32'h1 << ETC_FLG_WAKE);
      wr(ETC_ADR_CTRL_B, 32'h1, 1);
      attn_n = 1'b0;
      repeat (8) @(negedge sys_clk);
      check(slp, 32'h0);
      attn_n = 1'b1;
      // Deep sleep freezes the count; a due match cannot wake it
      wr(ETC_ADR_MASK, 32'h110, 1);
      wr(ETC_ADR_CMP_HI + 6'h02, {8'h00, cnt + 24'd900}, 2);
      wr(ETC_ADR_CTRL_B, 32'h1, 1);
      c0 = cnt;
      repeat (2000) @(negedge sys_clk);
      check(slp, 32'h1);
      check(cnt, c0);
      attn_n = 1'b0;
      repeat (8) @(negedge sys_clk);
      attn_n = 1'b1;
      check(slp, 32'h0);
      wr(ETC_ADR_CMP_HI + 6'h02, 32'h80000000, 2);
      rd(ETC_ADR_STATUS, 32'h0);
      // Packet trigger twice without clearing the enable bit
      op = 32'h1 + $urandom % 3;
      wr(ETC_ADR_MASK, 32'h2, 1);
      wr(ETC_ADR_CTRL_A, 32'h80 | op, 1);
      pin = 1'b1;
      for (int k = 0; k < 2; k++) begin
         t = cnt + 24'd3000;
         wr(ETC_ADR_CMP_HI + 6'h02, {8'h00, t}, 2);
         wait_trig();
         check(top, op);
         check(tstrm, 32'h0);
         check(irq_n, 32'h0);
         rd(ETC_ADR_STATUS, 32'h1 << ETC_FLG_CMP2);
      end
      // Stream trigger on the low half, then refused once cmp two is off
      pin = 1'b0;
      wr(ETC_ADR_CTRL_B, 32'ha, 1);
      pin = 1'b1;
      t = cnt + 24'd3000;
      wr(ETC_ADR_STREAM, {16'h0, t[15:0]}, 1);
      wait_trig();
      check(top, 32'h2);
      check(tstrm, 32'h1);
      wr(ETC_ADR_CMP_HI + 6'h02, 32'h80000000, 2);
      c0 = cnt + 24'd3000;
      wr(ETC_ADR_STREAM, {16'h0, c0[15:0]}, 1);
      op = trig_n;
      wait_cnt(c0 + 24'd8);
      check(trig_n, op);
      give_verdict();
   end
endmodule
`default_nettype wire
